// [hdl/cisl_event_cell.sv]
// one event: edge capture, sticky status bit and interrupt contribution
`timescale 1ns/1ps
module cisl_event_cell
  import cisl_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       cond_in,
  input  cisl_pkg::cisl_mode_t mode_in,
  input  wire logic       mask_in,
  input  wire logic       status_clr_in,
  input  wire logic       irq_clr_in,
  output logic            flag_out,
  output logic            irq_out
);
  import cisl_pkg::*;

  logic cond_q;
  logic cond_d;
  logic flag_q;
  logic flag_d;
  logic pend_q;
  logic pend_d;
  logic rise;
  logic fall;
  logic edge_hit;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    cond_d = cond_in;
    rise   = cond_in & ~cond_q;
    fall   = ~cond_in & cond_q;
    flag_d = rise | (flag_q & ~status_clr_in);
    unique case (mode_in)
      CISL_MODE_RISE:  edge_hit = rise;
      CISL_MODE_FALL:  edge_hit = fall;
      CISL_MODE_LEVEL: edge_hit = 1'b0;
      CISL_MODE_RSVD:  edge_hit = 1'b0;
    endcase
    pend_d = (edge_hit & ~mask_in) | (pend_q & ~irq_clr_in & ~mask_in);
    if (mode_in == CISL_MODE_LEVEL || mode_in == CISL_MODE_RSVD)
    begin
      pend_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      cond_q <= 1'b0;
      flag_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      cond_q <= cond_d;
      flag_q <= flag_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign flag_out = flag_q;
  assign irq_out  = ~mask_in & ((mode_in == CISL_MODE_LEVEL) ? cond_q : pend_q);

endmodule : cisl_event_cell

// [hdl/cisl_pkg.sv]
// types shared by the codec interrupt status logic
package cisl_pkg;

  // ----------------------------------------------------------------------
  // interrupt mode codes, in code order 00, 01, 10, 11
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CISL_MODE_RISE,
    CISL_MODE_FALL,
    CISL_MODE_LEVEL,
    CISL_MODE_RSVD
  } cisl_mode_t;

  // ----------------------------------------------------------------------
  // eight event conditions, laid out as the status register
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic dacb_left_automute_flag;
    logic dacb_right_automute_flag;
    logic daca_left_automute_flag;
    logic daca_right_automute_flag;
    logic port_b_clock_fault_flag;
    logic port_a_clock_fault_flag;
    logic adc_pos_clip_flag;
    logic adc_neg_clip_flag;
  } cisl_events_t;

  // ----------------------------------------------------------------------
  // one register access from the control port
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cisl_reg_req_t;

endpackage : cisl_pkg

// [hdl/cisl_regs.svh]
// register map, field positions and reset values of the codec interrupt status logic
`ifndef CISL_REGS_SVH
`define CISL_REGS_SVH

// ----------------------------------------------------------------------
// register offsets on the control port
// ----------------------------------------------------------------------
`define CISL_ADDR_W          8
`define CISL_DATA_W          8
`define CISL_ADDR_MODE       8'h16
`define CISL_ADDR_MASK       8'h17
`define CISL_ADDR_STATUS     8'h18

// ----------------------------------------------------------------------
// reset values and unmapped read data
// ----------------------------------------------------------------------
`define CISL_RST_MODE        8'h00
`define CISL_RST_MASK        8'h00
`define CISL_RST_STATUS      8'h00
`define CISL_RD_IDLE         8'h00

// ----------------------------------------------------------------------
// status and mask bit positions
// ----------------------------------------------------------------------
`define CISL_NUM_EVENTS      8
`define CISL_BIT_DACB_L      7
`define CISL_BIT_DACB_R      6
`define CISL_BIT_DACA_L      5
`define CISL_BIT_DACA_R      4
`define CISL_BIT_PORT_B      3
`define CISL_BIT_PORT_A      2
`define CISL_BIT_ADC_POS     1
`define CISL_BIT_ADC_NEG     0

// ----------------------------------------------------------------------
// mode register fields (low bit of each two-bit code)
// ----------------------------------------------------------------------
`define CISL_FLD_PORT_B      6
`define CISL_FLD_PORT_A      4
`define CISL_FLD_AUTOMUTE    2
`define CISL_FLD_ADC         0

`endif

// [hdl/cisl_top.sv]
// codec interrupt status logic: mode, mask and clear-on-read status registers
`timescale 1ns/1ps
`include "cisl_regs.svh"
module cisl_top
  import cisl_pkg::*;
(
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  input  cisl_pkg::cisl_reg_req_t  reg_req_in,
  input  cisl_pkg::cisl_events_t   event_cond_in,
  output logic [`CISL_DATA_W-1:0]  reg_rdata_out,
  output logic                     reg_rvalid_out,
  output logic                     int_req_out,
  output logic                     adc_clip_live_pin_out
);
  import cisl_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [`CISL_DATA_W-1:0]    mode_q;
  logic [`CISL_DATA_W-1:0]    mode_d;
  logic [`CISL_DATA_W-1:0]    mask_q;
  logic [`CISL_DATA_W-1:0]    mask_d;
  logic [`CISL_DATA_W-1:0]    rdata_q;
  logic [`CISL_DATA_W-1:0]    rdata_d;
  logic                       rvalid_q;
  logic                       rvalid_d;
  logic                       int_q;
  logic                       int_d;
  logic                       clip_q;
  logic                       clip_d;
  logic                       status_rd;
  logic                       irq_clr;
  logic [`CISL_NUM_EVENTS-1:0] cond_vec;
  logic [`CISL_NUM_EVENTS-1:0] flag_vec;
  logic [`CISL_NUM_EVENTS-1:0] irq_vec;
  cisl_mode_t                 bit_mode [`CISL_NUM_EVENTS];

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------

  // true when a register access hits the given offset
  function automatic logic hit(input logic [`CISL_ADDR_W-1:0] addr,
                               input logic [`CISL_ADDR_W-1:0] target);
    hit = (addr == target);
  endfunction : hit

  // two-bit code at the given field position of the mode register
  function automatic cisl_mode_t field(input logic [`CISL_DATA_W-1:0] modes,
                                       input int                      lsb);
    field = cisl_mode_t'(modes[lsb +: 2]);
  endfunction : field

  // code governing one status bit
  function automatic cisl_mode_t mode_of(input logic [`CISL_DATA_W-1:0] modes,
                                         input int                      idx);
    if (idx == `CISL_BIT_PORT_B)
      mode_of = field(modes, `CISL_FLD_PORT_B);
    else if (idx == `CISL_BIT_PORT_A)
      mode_of = field(modes, `CISL_FLD_PORT_A);
    else if (idx == `CISL_BIT_ADC_POS || idx == `CISL_BIT_ADC_NEG)
      mode_of = field(modes, `CISL_FLD_ADC);
    else
      mode_of = field(modes, `CISL_FLD_AUTOMUTE);
  endfunction : mode_of

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------

  assign status_rd = reg_req_in.rd & hit(reg_req_in.addr, `CISL_ADDR_STATUS);
  assign irq_clr   = status_rd & int_q;

  // ----------------------------------------------------------------------
  // event sources in status bit order
  // ----------------------------------------------------------------------

  assign cond_vec[`CISL_BIT_DACB_L]  = event_cond_in.dacb_left_automute_flag;
  assign cond_vec[`CISL_BIT_DACB_R]  = event_cond_in.dacb_right_automute_flag;
  assign cond_vec[`CISL_BIT_DACA_L]  = event_cond_in.daca_left_automute_flag;
  assign cond_vec[`CISL_BIT_DACA_R]  = event_cond_in.daca_right_automute_flag;
  assign cond_vec[`CISL_BIT_PORT_B]  = event_cond_in.port_b_clock_fault_flag;
  assign cond_vec[`CISL_BIT_PORT_A]  = event_cond_in.port_a_clock_fault_flag;
  assign cond_vec[`CISL_BIT_ADC_POS] = event_cond_in.adc_pos_clip_flag;
  assign cond_vec[`CISL_BIT_ADC_NEG] = event_cond_in.adc_neg_clip_flag;

  // ----------------------------------------------------------------------
  // per-event cells
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < `CISL_NUM_EVENTS; i++)
    begin : g_event
      assign bit_mode[i] = mode_of(mode_q, i);

      cisl_event_cell u_cell (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .cond_in       (cond_vec[i]),
        .mode_in       (bit_mode[i]),
        .mask_in       (mask_q[i]),
        .status_clr_in (status_rd),
        .irq_clr_in    (irq_clr),
        .flag_out      (flag_vec[i]),
        .irq_out       (irq_vec[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // mode and mask registers
  // ----------------------------------------------------------------------

  // next values of the writable registers
  always_comb
  begin
    mode_d = mode_q;
    mask_d = mask_q;
    if (reg_req_in.wr && hit(reg_req_in.addr, `CISL_ADDR_MODE))
    begin
      mode_d = reg_req_in.wdata;
    end
    if (reg_req_in.wr && hit(reg_req_in.addr, `CISL_ADDR_MASK))
    begin
      mask_d = reg_req_in.wdata;
    end
  end

  // register the configuration
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      mode_q <= `CISL_RST_MODE;
      mask_q <= `CISL_RST_MASK;
    end
    else
    begin
      mode_q <= mode_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------

  // select read data; writes to status fall through untouched
  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = reg_req_in.rd;
    if (reg_req_in.rd)
    begin
      if (hit(reg_req_in.addr, `CISL_ADDR_MODE))
        rdata_d = mode_q;
      else if (hit(reg_req_in.addr, `CISL_ADDR_MASK))
        rdata_d = mask_q;
      else if (hit(reg_req_in.addr, `CISL_ADDR_STATUS))
        rdata_d = flag_vec;
      else
        rdata_d = `CISL_RD_IDLE;
    end
  end

  // register read answer
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      rdata_q  <= `CISL_RST_STATUS;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt and overflow pins
  // ----------------------------------------------------------------------

  // combine unmasked contributions and the live overflow level
  always_comb
  begin
    int_d  = |irq_vec;
    clip_d = event_cond_in.adc_pos_clip_flag | event_cond_in.adc_neg_clip_flag;
  end

  // register the pins
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      int_q  <= 1'b0;
      clip_q <= 1'b0;
    end
    else
    begin
      int_q  <= int_d;
      clip_q <= clip_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_out         = rdata_q;
  assign reg_rvalid_out        = rvalid_q;
  assign int_req_out           = int_q;
  assign adc_clip_live_pin_out = clip_q;

endmodule : cisl_top

// [testbench/cisl_host_model.sv]
// host controller model driving the control port
`timescale 1ns/1ps
module cisl_host_model
  import cisl_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic [7:0]        rdata_in,
  input  wire logic              rvalid_in,
  output cisl_pkg::cisl_reg_req_t req_out
);
  initial req_out = '0;
  // one write strobe, idle bus shows the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    req_out <= '{1'b0, 1'b1, a, d};
    @(posedge core_clk_in);
    req_out <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  // one read strobe, data taken while rvalid stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    req_out <= '{1'b1, 1'b0, a, 8'h5a};
    @(posedge core_clk_in);
    req_out <= '{1'b0, 1'b0, ~a, 8'ha5};
    @(negedge core_clk_in);
    while (rvalid_in !== 1'b1 && n < 4)
    begin
      n++;
      @(negedge core_clk_in);
    end
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
  endtask : rd
endmodule : cisl_host_model

// [testbench/cisl_monitor.sv]
// port checker of the interrupt status logic
`timescale 1ns/1ps
module cisl_monitor
  import cisl_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  input  cisl_pkg::cisl_reg_req_t reg_req_in,
  input  cisl_pkg::cisl_events_t  event_cond_in,
  input  wire logic [7:0]        reg_rdata_out,
  input  wire logic              reg_rvalid_out,
  input  wire logic              int_req_out,
  input  wire logic              adc_clip_live_pin_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic rds;
  // status read strobe
  assign rds = reg_req_in.rd && reg_req_in.addr == 8'h18;

  property p_reset;
    rst_n_in && !$past(rst_n_in) |-> !int_req_out && !reg_rvalid_out && reg_rdata_out == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
  property p_rvalid;
    $past(rst_n_in) |-> reg_rvalid_out == $past(reg_req_in.rd);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("rvalid not one cycle after rd");
  property p_hold;
    $past(rst_n_in) && !reg_rvalid_out |-> $stable(reg_rdata_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_unmapped;
    reg_req_in.rd && !(reg_req_in.addr inside {[8'h16:8'h18]}) |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_live;
    $past(rst_n_in) |-> adc_clip_live_pin_out == $past(event_cond_in[1] | event_cond_in[0]);
  endproperty
  a_live: assert property (p_live) else $error("clip pin not live state");
  property p_race;
    rds && $rose(event_cond_in[7]) ##1 !rds ##1 rds |=> reg_rdata_out[7];
  endproperty
  a_race: assert property (p_race) else $error("event lost at read");
  property p_neg;
    $rose(event_cond_in[0]) ##1 !rds[*3] ##1 rds |=> reg_rdata_out[0];
  endproperty
  a_neg: assert property (p_neg) else $error("bit 0 not latched");
  property p_clear;
    $past(rst_n_in) && rds && $stable(event_cond_in) ##1 !rds && $stable(event_cond_in)
      ##1 rds |=> reg_rdata_out == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared by read");
endmodule : cisl_monitor

bind cisl_top cisl_monitor cisl_monitor_i (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
  .event_cond_in(event_cond_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .int_req_out(int_req_out),
  .adc_clip_live_pin_out(adc_clip_live_pin_out));

// [testbench/codec_interrupt_status_logic_tb.sv]
// self-checking bench of the interrupt status logic
`timescale 1ns/1ps
module codec_interrupt_status_logic_tb;
  import cisl_pkg::*;
  logic          core_clk;
  logic          rst_n;
  cisl_events_t  cond;
  cisl_reg_req_t req;
  logic [7:0]    rdata;
  logic          rvalid;
  logic          irq;
  logic          live;
  int            miscompares;
  int            checks;
  int            flds[4] = '{6, 4, 2, 0};
  int            bits[4] = '{3, 2, 4, 1};

  cisl_top cisl_top_i (.core_clk_in(core_clk), .rst_n_in(rst_n), .reg_req_in(req),
    .event_cond_in(cond), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .int_req_out(irq), .adc_clip_live_pin_out(live));
  cisl_host_model cisl_host_model_i (.core_clk_in(core_clk), .rdata_in(rdata),
    .rvalid_in(rvalid), .req_out(req));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    cisl_host_model_i.rd(a, d);
    chk(nm, exp, d);
  endtask : rdchk
  task automatic irqchk(input logic exp, input string nm);
    @(negedge core_clk);
    chk(nm, {7'h00, exp}, {7'h00, irq});
  endtask : irqchk

  task automatic t_regs;
    rdchk(8'h17, 8'h00, "mask");
    rdchk(8'h18, 8'h00, "status");
    cisl_host_model_i.wr(8'h18, 8'hff);
    rdchk(8'h18, 8'h00, "status wr");
    rdchk(8'h3c, 8'h00, "unmapped");
    rdchk(8'h16, 8'h00, "mode rst");
    cisl_host_model_i.wr(8'h16, 8'h9c);
    rdchk(8'h16, 8'h9c, "mode");
    cisl_host_model_i.wr(8'h17, 8'h5a);
    rdchk(8'h17, 8'h5a, "mask wr");
    $display("test regs done");
  endtask : t_regs
  task automatic t_bits;
    logic [7:0] b;
    cisl_host_model_i.wr(8'h17, 8'hff);
    for (int i = 0; i < 8; i++)
    begin
      b = 8'h01 << i;
      @(posedge core_clk);
      cond <= b;
      @(posedge core_clk);
      cond <= '0;
      repeat (2) @(posedge core_clk);
      rdchk(8'h18, b, "bit");
      chk("masked irq", 8'h00, {7'h00, irq});
      rdchk(8'h18, 8'h00, "cleared");
    end
    $display("test bits done");
  endtask : t_bits
  task automatic t_mode(input int fld, input int bn, input logic [1:0] code);
    cisl_host_model_i.wr(8'h16, 8'(code) << fld);
    @(posedge core_clk);
    cond <= cisl_events_t'(8'h01 << bn);
    repeat (3) @(posedge core_clk);
    irqchk(code == 2'b00 || code == 2'b10, "irq on");
    @(posedge core_clk);
    cond <= '0;
    repeat (3) @(posedge core_clk);
    irqchk(code == 2'b00 || code == 2'b01, "irq off");
    rdchk(8'h18, 8'h01 << bn, "bit");
    repeat (2) @(posedge core_clk);
    irqchk(1'b0, "irq read");
  endtask : t_mode
  task automatic t_mask;
    cisl_host_model_i.wr(8'h17, 8'h0a);
    cisl_host_model_i.wr(8'h16, 8'h00);
    @(posedge core_clk);
    cond <= 8'h0a;
    repeat (3) @(posedge core_clk);
    irqchk(1'b0, "masked");
    chk("live", 8'h01, {7'h00, live});
    @(posedge core_clk);
    cond <= '0;
    repeat (2) @(posedge core_clk);
    irqchk(1'b0, "masked");
    chk("live", 8'h00, {7'h00, live});
    rdchk(8'h18, 8'h0a, "masked bits");
    $display("test mask done");
  endtask : t_mask
  task automatic t_race;
    cisl_host_model_i.wr(8'h17, 8'hff);
    fork
      rdchk(8'h18, 8'h00, "read at event");
      begin
        @(posedge core_clk);
        cond <= 8'h80;
      end
    join
    rdchk(8'h18, 8'h80, "event kept");
    $display("test race done");
  endtask : t_race

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // watchdog over about 5000 cycles
  initial
  begin
    #125000;
    miscompares++;
    test_done();
  end

  initial
  begin
    miscompares = 0;
    checks = 0;
    cond = '0;
    rst_n = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_bits();
    cisl_host_model_i.wr(8'h17, 8'h00);
    for (int g = 0; g < 4; g++)
      for (int c = 0; c < 4; c++)
        t_mode(flds[g], bits[g], 2'(c));
    $display("test modes done");
    t_mask();
    t_race();
    test_done();
  end
endmodule : codec_interrupt_status_logic_tb
